// ---- rtl/dcc_pkg.sv ----
// dcc_pkg: register map, field positions, reset values and mode table
// for the dual comparator control block.
// assumes an AXI4-Lite master with 32-bit data and word-aligned offsets.
`default_nettype none

package dcc_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] DCC_OFS_CONTROL = 8'h00; // comparator_control
  localparam logic [7:0] DCC_OFS_FLAGS = 8'h04; // peripheral_flags_two
  localparam logic [7:0] DCC_OFS_ENABLES = 8'h08; // peripheral_enables_two
  localparam logic [7:0] DCC_OFS_INTCTL = 8'h0C; // interrupt_control
  localparam logic [7:0] DCC_OFS_DIR = 8'h10; // port_f_direction
  localparam logic [7:0] DCC_OFS_PORT = 8'h14; // port f pins / latch
  localparam int DCC_ADDR_W = 8;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int DCC_BIT_CMP2_RESULT = 7;
  localparam int DCC_BIT_CMP1_RESULT = 6;
  localparam int DCC_BIT_CMP2_INVERT = 5;
  localparam int DCC_BIT_CMP1_INVERT = 4;
  localparam int DCC_BIT_INPUT_SWITCH = 3;
  localparam int DCC_MODE_HI = 2;
  localparam int DCC_MODE_LO = 0;
  localparam int DCC_BIT_CHANGE_FLAG = 6;
  localparam int DCC_BIT_CHANGE_ENABLE = 6;
  localparam int DCC_BIT_PERIPH_EN = 6;
  localparam int DCC_BIT_GLOBAL_EN = 7;
  localparam int DCC_PIN_CMP1_OUT = 1;
  localparam int DCC_PIN_CMP2_OUT = 2;

  // ---------------------------------------------------------------
  // reset values and masks
  // ---------------------------------------------------------------
  localparam logic [7:0] DCC_CONTROL_RESET = 8'h07;
  localparam logic [7:0] DCC_DIR_RESET = 8'hFE;
  localparam logic [7:0] DCC_PORT_MASK = 8'hFE; // bit 0 not present
  localparam logic [7:0] DCC_CTRL_WMASK = 8'h3F; // result bits read-only
  localparam logic [1:0] DCC_RESP_OKAY = 2'h0;
  localparam logic [1:0] DCC_RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // comparator modes and mode table
  // ---------------------------------------------------------------
  localparam logic [2:0] DCC_MODE_FOUR_MUX = 3'h6;
  localparam logic [2:0] DCC_MODE_OFF = 3'h7;

  typedef struct packed {
    logic cmp1_on;
    logic cmp2_on;
    logic out_route; // results drive the two output pins
    logic ref_use; // internal reference on both positive inputs
  } dcc_mode_entry_t;

  // entries for modes other than four-mux and off are table data
  localparam dcc_mode_entry_t DCC_MODE_TABLE [8] = '{
    '{1'b1, 1'b1, 1'b0, 1'b0}, // mode 0
    '{1'b1, 1'b1, 1'b0, 1'b0}, // mode 1
    '{1'b1, 1'b1, 1'b0, 1'b0}, // mode 2
    '{1'b1, 1'b1, 1'b1, 1'b0}, // mode 3
    '{1'b1, 1'b1, 1'b0, 1'b0}, // mode 4
    '{1'b1, 1'b1, 1'b1, 1'b0}, // mode 5
    '{1'b1, 1'b1, 1'b0, 1'b1}, // mode 6: four inputs, two comparators
    '{1'b0, 1'b0, 1'b0, 1'b0} // mode 7: both comparators off
  };

  // control word handed to the analog comparator core
  typedef struct packed {
    logic [2:0] mode;
    logic cmp1_enable;
    logic cmp2_enable;
    logic input_switch_select; // 1: ref-capable pin / pin eight
    logic ref_to_vinplus;
  } dcc_analog_t;

endpackage

`default_nettype wire

// ---- rtl/dcc_top.sv ----
// dcc_top: control and status logic around two analog comparators,
// reached over AXI4-Lite.
// assumes raw comparator results arrive asynchronously from the analog
// core; the port pins are driven by a pad ring outside this block.
//
// Function
// - comparator 2 result is 1 when plus above minus, invert reverses
// - comparator 1 result is 1 when plus above minus, invert reverses
// - control bits 5:4 invert each comparator output at pin and result
// - in mode 110 input switch selects which pins feed negative inputs
// - three low control bits select one of eight modes
// - internal reference only in mode 110, onto both positive inputs
// - result bits are read-only; writes leave them alone
// - routing modes switch output pins to unsynchronized comparator outputs
// - direction bits still enable the routed output pins
// - port direction register sets pin direction in every mode
// - port reads return 0 on pins configured analog
// - change flag sets whenever either comparator output changes
// - change flag cleared by writing 0; writing 1 sets it
// - request only with change, peripheral and global enables set
// - change flag still sets with interrupt enables clear
// - a change coinciding with a control read may be missed
// - any control read or write captures outputs as new reference
// - persisting mismatch keeps setting the change flag
// - mode 111 turns comparators off; reset selects it
// - comparators run in sleep, interrupt wakes, control register kept
`default_nettype none

module dcc_top
  import dcc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [dcc_pkg::DCC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dcc_pkg::DCC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog comparator core
  input wire logic cmp1_raw,
  input wire logic cmp2_raw,
  output dcc_pkg::dcc_analog_t analog_ctrl,
  // port f pads and analog configuration
  input wire logic [7:0] port_f_in,
  output logic [7:0] port_f_out,
  output logic [7:0] port_f_oe,
  input wire logic [7:0] analog_pin_select,
  // system
  input wire logic sleep_active,
  output logic irq_request,
  output logic wake_request
);

  import dcc_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [5:0] ctrl_reg; // invert, switch and mode bits
  logic change_flag_reg;
  logic change_enable_reg;
  logic periph_en_reg;
  logic global_en_reg;
  logic [7:0] dir_reg;
  logic [7:0] latch_reg;
  logic [1:0] snapshot_reg; // last captured result bits
  logic [1:0] cmp_s1, cmp_s2, cmp_s3, cmp_stable;
  logic [7:0] pin_s1, pin_s2, pin_s3, pin_stable;

  // AXI state
  logic aw_full_reg, w_full_reg;
  logic [DCC_ADDR_W-1:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_lane0_reg;
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  logic [2:0] mode;
  dcc_mode_entry_t mode_entry;
  logic [1:0] invert;
  logic [1:0] result;
  logic mismatch;
  logic wr_exec, rd_take, ctrl_touch;
  logic [7:0] ctrl_read, port_read;
  logic [31:0] rd_word;
  logic rd_hit;

  assign mode = ctrl_reg[DCC_MODE_HI:DCC_MODE_LO];
  assign mode_entry = DCC_MODE_TABLE[mode];
  assign invert = {ctrl_reg[DCC_BIT_CMP2_INVERT],
                   ctrl_reg[DCC_BIT_CMP1_INVERT]};

  // ---------------------------------------------------------------
  // input synchronizers
  // ---------------------------------------------------------------
  // three stages; a new level counts once stages two and three agree,
  // so a single glitchy sample never reaches the mismatch logic
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmp_s1 <= 2'h0;
      cmp_s2 <= 2'h0;
      cmp_s3 <= 2'h0;
      cmp_stable <= 2'h0;
    end
    else
    begin
      cmp_s1 <= {cmp2_raw, cmp1_raw};
      cmp_s2 <= cmp_s1;
      cmp_s3 <= cmp_s2;
      cmp_stable <= (cmp_s2 & cmp_s3) | (cmp_stable & (cmp_s2 ^ cmp_s3));
    end
  end

  // port pins, same filter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1 <= 8'h00;
      pin_s2 <= 8'h00;
      pin_s3 <= 8'h00;
      pin_stable <= 8'h00;
    end
    else
    begin
      pin_s1 <= port_f_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_stable <= (pin_s2 & pin_s3) | (pin_stable & (pin_s2 ^ pin_s3));
    end
  end

  // ---------------------------------------------------------------
  // results and mismatch detection
  // ---------------------------------------------------------------
  // an off comparator reports a low raw level before inversion
  assign result[0] = (cmp_stable[0] & mode_entry.cmp1_on) ^
                     invert[0];
  assign result[1] = (cmp_stable[1] & mode_entry.cmp2_on) ^
                     invert[1];
  assign mismatch = (result != snapshot_reg);

  // any control access takes a fresh snapshot; a change landing in the
  // same cycle still raises the flag, so the tolerated miss never occurs
  assign ctrl_touch = (rd_take && s_axi_araddr == DCC_OFS_CONTROL) ||
                      (wr_exec && aw_addr_reg == DCC_OFS_CONTROL);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      snapshot_reg <= 2'h0;
    else if (ctrl_touch)
      snapshot_reg <= result;
  end

  // ---------------------------------------------------------------
  // change flag
  // ---------------------------------------------------------------
  // hardware set beats a software clear in the same cycle, so a
  // standing mismatch keeps the flag up until the snapshot catches up
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      change_flag_reg <= 1'b0;
    else if (mismatch)
      change_flag_reg <= 1'b1;
    else if (wr_exec && w_lane0_reg && aw_addr_reg == DCC_OFS_FLAGS)
      change_flag_reg <= w_data_reg[DCC_BIT_CHANGE_FLAG];
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  // result bits have no storage here, so writes cannot touch them
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_reg <= DCC_CONTROL_RESET[5:0];
    else if (wr_exec && w_lane0_reg && aw_addr_reg == DCC_OFS_CONTROL)
      ctrl_reg <= w_data_reg[5:0] & DCC_CTRL_WMASK[5:0];
  end

  // interrupt enables
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      change_enable_reg <= 1'b0;
      periph_en_reg <= 1'b0;
      global_en_reg <= 1'b0;
    end
    else if (wr_exec && w_lane0_reg)
    begin
      if (aw_addr_reg == DCC_OFS_ENABLES)
        change_enable_reg <= w_data_reg[DCC_BIT_CHANGE_ENABLE];
      if (aw_addr_reg == DCC_OFS_INTCTL)
      begin
        periph_en_reg <= w_data_reg[DCC_BIT_PERIPH_EN];
        global_en_reg <= w_data_reg[DCC_BIT_GLOBAL_EN];
      end
    end
  end

  // port direction and output latch
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dir_reg <= DCC_DIR_RESET;
      latch_reg <= 8'h00;
    end
    else if (wr_exec && w_lane0_reg)
    begin
      if (aw_addr_reg == DCC_OFS_DIR)
        dir_reg <= w_data_reg & DCC_PORT_MASK;
      if (aw_addr_reg == DCC_OFS_PORT)
        latch_reg <= w_data_reg & DCC_PORT_MASK;
    end
  end

  // ---------------------------------------------------------------
  // interrupt, wake and analog control outputs
  // ---------------------------------------------------------------
  // wake needs only the local enable; the flag itself keeps running
  // in sleep and the control register is never disturbed by waking
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_request <= 1'b0;
      wake_request <= 1'b0;
      analog_ctrl <= '0;
    end
    else
    begin
      irq_request <= change_flag_reg & change_enable_reg &
                     periph_en_reg & global_en_reg;
      wake_request <= sleep_active & change_flag_reg &
                      change_enable_reg;
      analog_ctrl.mode <= mode;
      analog_ctrl.cmp1_enable <= mode_entry.cmp1_on;
      analog_ctrl.cmp2_enable <= mode_entry.cmp2_on;
      analog_ctrl.input_switch_select <= (mode == DCC_MODE_FOUR_MUX) &&
          ctrl_reg[DCC_BIT_INPUT_SWITCH];
      analog_ctrl.ref_to_vinplus <= mode_entry.ref_use &&
          (mode == DCC_MODE_FOUR_MUX);
    end
  end

  // ---------------------------------------------------------------
  // port f pads
  // ---------------------------------------------------------------
  // direction 0 drives the pad in every mode, routed or not
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      port_f_oe <= 8'h00;
    else
      port_f_oe <= ~dir_reg & DCC_PORT_MASK;
  end

  // the routed pins carry the raw comparator level so that edge
  // timing is not quantised by the clock; other pins come from flops
  always_comb
  begin
    port_f_out = latch_reg;
    if (mode_entry.out_route)
    begin
      port_f_out[DCC_PIN_CMP1_OUT] = cmp1_raw ^ invert[0];
      port_f_out[DCC_PIN_CMP2_OUT] = cmp2_raw ^ invert[1];
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  assign ctrl_read = {result[1], result[0], ctrl_reg};
  assign port_read = pin_stable & ~analog_pin_select & DCC_PORT_MASK;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      DCC_OFS_CONTROL: rd_word[7:0] = ctrl_read;
      DCC_OFS_FLAGS: rd_word[DCC_BIT_CHANGE_FLAG] = change_flag_reg;
      DCC_OFS_ENABLES: rd_word[DCC_BIT_CHANGE_ENABLE] = change_enable_reg;
      DCC_OFS_INTCTL:
      begin
        rd_word[DCC_BIT_PERIPH_EN] = periph_en_reg;
        rd_word[DCC_BIT_GLOBAL_EN] = global_en_reg;
      end
      DCC_OFS_DIR: rd_word[7:0] = dir_reg;
      DCC_OFS_PORT: rd_word[7:0] = port_read;
      default: rd_hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  // address and data are held separately and may arrive in any order;
  // the register update happens one edge after both are held
  assign wr_exec = aw_full_reg && w_full_reg && !bvalid_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 8'h00;
      w_lane0_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= DCC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && awready_reg)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid && wready_reg)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane0_reg <= s_axi_wstrb[0];
        wready_reg <= 1'b0;
      end
      if (wr_exec)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (aw_addr_reg == DCC_OFS_CONTROL ||
                      aw_addr_reg == DCC_OFS_FLAGS ||
                      aw_addr_reg == DCC_OFS_ENABLES ||
                      aw_addr_reg == DCC_OFS_INTCTL ||
                      aw_addr_reg == DCC_OFS_DIR ||
                      aw_addr_reg == DCC_OFS_PORT) ?
                     DCC_RESP_OKAY : DCC_RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready)
      begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  assign rd_take = s_axi_arvalid && arready_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= DCC_RESP_OKAY;
    end
    else
    begin
      if (rd_take)
      begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= rd_hit ? DCC_RESP_OKAY : DCC_RESP_SLVERR;
      end
      else if (rvalid_reg && s_axi_rready)
      begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule

`default_nettype wire

// ---- testbench/dcc_top_monitor.sv ----
// dcc_top_monitor: port level assertions for the comparator control block
// assumes it is bound to dcc_top and sees only that module's ports
`default_nettype none

module dcc_top_monitor
  import dcc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic cmp1_raw,
  input wire logic cmp2_raw,
  input wire dcc_pkg::dcc_analog_t analog_ctrl,
  input wire logic [7:0] port_f_out,
  input wire logic [7:0] port_f_oe,
  input wire logic sleep_active,
  input wire logic wake_request
);
  logic route;

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  // pins follow the raw comparators only in routing modes
  assign route = DCC_MODE_TABLE[analog_ctrl.mode].out_route;
  default clocking mon_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // a write may move mode or invert, so its response cycle is skipped
  AST_ROUTE_PIN1: assert property (
    route && !s_axi_bvalid |-> $stable(port_f_out[1] ^ cmp1_raw))
    else $error("pin one lost its comparator");
  AST_ROUTE_PIN2: assert property (
    route && !s_axi_bvalid |-> $stable(port_f_out[2] ^ cmp2_raw))
    else $error("pin two lost its comparator");
  AST_LATCH_HOLD: assert property (
    !route && !s_axi_bvalid |-> $stable(port_f_out))
    else $error("port data moved without a write");
  // the enable flop lags a direction write by one more edge
  AST_OE_DIR: assert property (
    !s_axi_bvalid && !$past(s_axi_bvalid) |->
    $stable(port_f_oe) && !port_f_oe[0])
    else $error("output enable moved without a write");
  AST_WAKE_SLEEP: assert property (
    wake_request |-> $past(sleep_active))
    else $error("wake without sleep");
  AST_READ_ANS: assert property (
    s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("read answer late or wide");
  AST_WRITE_ANS: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
    ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_RESET_OFF: assert property (
    $rose(aresetn) |=>
    analog_ctrl.mode == DCC_MODE_OFF && !analog_ctrl.cmp1_enable)
    else $error("reset did not select off mode");
  AST_ENABLE_TABLE: assert property (
    !$rose(aresetn) |->
    analog_ctrl.cmp1_enable == DCC_MODE_TABLE[analog_ctrl.mode].cmp1_on &&
    analog_ctrl.cmp2_enable == DCC_MODE_TABLE[analog_ctrl.mode].cmp2_on)
    else $error("comparator power disagrees with mode");
  AST_REF_MODE6: assert property (
    analog_ctrl.ref_to_vinplus == (analog_ctrl.mode == DCC_MODE_FOUR_MUX))
    else $error("reference outside four input mode");
endmodule

bind dcc_top dcc_top_monitor i_dcc_top_monitor (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rdata, .cmp1_raw, .cmp2_raw, .analog_ctrl, .port_f_out,
  .port_f_oe, .sleep_active, .wake_request);

`default_nettype wire

// ---- testbench/dcc_analog_model.sv ----
// dcc_analog_model: behavioural comparators, pins and reference
// assumes the bench sets pin levels and the command levels directly
`default_nettype none

module dcc_analog_model
  import dcc_pkg::*;
(
  input wire logic aclk,
  input wire dcc_pkg::dcc_analog_t analog_ctrl,
  input wire logic [7:0] lvl_ref,
  input wire logic [7:0] lvl_8,
  input wire logic [7:0] lvl_9,
  input wire logic [7:0] lvl_10,
  input wire logic [7:0] lvl_11,
  input wire logic cmd1,
  input wire logic cmd2,
  input wire logic slow,
  output logic cmp1_raw,
  output logic cmp2_raw
);
  timeunit 1ns;
  timeprecision 1ns;
  logic t1, t2;
  logic q1 = 1'b0;
  logic q2 = 1'b0;
  logic junk = 1'b0;

  // plus above minus gives 1; four input mode uses the reference
  always_comb
  begin
    t1 = cmd1;
    t2 = cmd2;
    if (analog_ctrl.ref_to_vinplus)
    begin
      t1 = analog_ctrl.input_switch_select ? lvl_ref > lvl_10 :
           lvl_ref > lvl_11;
      t2 = analog_ctrl.input_switch_select ? lvl_ref > lvl_8 :
           lvl_ref > lvl_9;
    end
  end

  // response time; slow mimics a long settling comparator
  always @(t1) q1 <= #(slow ? 97 : 3) t1;
  always @(t2) q2 <= #(slow ? 97 : 3) t2;

  // a powered down comparator gives no valid level, so it wanders
  always @(posedge aclk) junk <= !junk;
  assign cmp1_raw = analog_ctrl.cmp1_enable ? q1 : junk;
  assign cmp2_raw = analog_ctrl.cmp2_enable ? q2 : !junk;
endmodule

`default_nettype wire

// ---- testbench/dcc_top_bench.sv ----
// dcc_top_bench: self-checking bench for the comparator control block
// assumes dcc_top, dcc_analog_model and the bound monitor are compiled
`default_nettype none

module dcc_top_bench
  import dcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cmp1_raw, cmp2_raw, irq_request, wake_request;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  dcc_analog_t analog_ctrl;
  logic [7:0] port_f_in = 8'h00, analog_pin_select = 8'h00;
  logic [7:0] port_f_out, port_f_oe;
  logic sleep_active = 1'b0, cmd1 = 1'b0, cmd2 = 1'b0, slow = 1'b0;
  logic [7:0] lvl_ref = 8'h64, lvl_8 = 8'h32, lvl_9 = 8'h96;
  logic [7:0] lvl_10 = 8'h96, lvl_11 = 8'h32;
  int fails = 0, num_checks = 0, seed = 14;
  logic [33:0] rq[$];
  logic [1:0] bq[$];

  dcc_top i_dcc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp1_raw, .cmp2_raw,
    .analog_ctrl, .port_f_in, .port_f_out, .port_f_oe, .analog_pin_select,
    .sleep_active, .irq_request, .wake_request);
  dcc_analog_model i_dcc_analog_model (.aclk, .analog_ctrl, .lvl_ref,
    .lvl_8, .lvl_9, .lvl_10, .lvl_11, .cmd1, .cmd2, .slow, .cmp1_raw,
    .cmp2_raw);

  // ---------------------------------------------------------------
  // clock, compare and bus tasks
  // ---------------------------------------------------------------
  initial
  begin
    forever #10 aclk = ~aclk;
  end

  task automatic check34(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // called just after an edge; the response is noted before it comes
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er = DCC_RESP_OKAY);
    int n;
    n = 0;
    bq.push_back(er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end
    while (!s_axi_bvalid && n < 50);
    if (n >= 50) fails++;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er = DCC_RESP_OKAY);
    int n;
    n = 0;
    rq.push_back({er, 24'h0, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end
    while (!s_axi_rvalid && n < 50);
    if (n >= 50) fails++;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // each answer is matched against the oldest note
  always @(posedge aclk)
  begin
    if (s_axi_bvalid && s_axi_bready)
      check34({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
    if (s_axi_rvalid && s_axi_rready)
      check34({s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end

  // hang guard, far beyond the several hundred cycles needed
  initial
  begin
    #200000;
    fails++;
    give_verdict();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial
  begin
    logic [7:0] r;
    logic [3:0] kv;
    logic [2:0] ev;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(DCC_OFS_CONTROL, DCC_CONTROL_RESET);
    rd(DCC_OFS_DIR, DCC_DIR_RESET);
    rd(DCC_OFS_FLAGS, 8'h00);
    rd(8'h18, 8'h00, DCC_RESP_SLVERR);
    wr(8'h1C, 8'hFF, DCC_RESP_SLVERR);
    // interrupts stay disabled while the mode is walked
    for (int m = 0; m < 8; m++)
    begin
      wr(DCC_OFS_CONTROL, 8'hC0 | 8'(m));
      rd(DCC_OFS_CONTROL, 8'(m));
      check34({33'h0, analog_ctrl.cmp1_enable},
              {33'h0, DCC_MODE_TABLE[m].cmp1_on});
    end
    for (int k = 0; k < 16; k++)
    begin
      kv = 4'(k);
      cmd1 <= kv[0];
      cmd2 <= kv[1];
      wr(DCC_OFS_CONTROL, {2'b00, kv[3:2], 4'h0});
      repeat (8) @(posedge aclk);
      rd(DCC_OFS_CONTROL, {kv[3:2] ^ kv[1:0], kv[3:2], 4'h0});
    end
    wr(DCC_OFS_FLAGS, 8'h00);
    rd(DCC_OFS_FLAGS, 8'h00);
    slow <= 1'b1;
    cmd1 <= 1'b0;
    repeat (12) @(posedge aclk);
    wr(DCC_OFS_FLAGS, 8'h00);
    rd(DCC_OFS_FLAGS, 8'h40);
    rd(DCC_OFS_CONTROL, 8'h70);
    wr(DCC_OFS_FLAGS, 8'h00);
    rd(DCC_OFS_FLAGS, 8'h00);
    wr(DCC_OFS_FLAGS, 8'h40);
    rd(DCC_OFS_FLAGS, 8'h40);
    slow <= 1'b0;
    for (int e = 0; e < 8; e++)
    begin
      ev = 3'(e);
      wr(DCC_OFS_ENABLES, {1'b0, ev[0], 6'h0});
      wr(DCC_OFS_INTCTL, {ev[2:1], 6'h0});
      repeat (2) @(posedge aclk);
      check34({33'h0, irq_request}, {33'h0, &ev});
    end
    rd(DCC_OFS_FLAGS, 8'h40);
    sleep_active <= 1'b1;
    repeat (3) @(posedge aclk);
    check34({33'h0, wake_request}, {33'h0, 1'b1});
    rd(DCC_OFS_CONTROL, 8'h70);
    sleep_active <= 1'b0;
    wr(DCC_OFS_ENABLES, 8'h00);
    r = 8'($random(seed));
    wr(DCC_OFS_DIR, r);
    wr(DCC_OFS_PORT, ~r);
    wr(DCC_OFS_CONTROL, 8'h13);
    repeat (8) @(posedge aclk);
    check34({26'h0, port_f_oe}, {26'h0, ~r & DCC_PORT_MASK});
    check34({32'h0, port_f_out[2:1]}, {32'h0, cmd2, !cmd1});
    for (int s = 0; s < 2; s++)
    begin
      wr(DCC_OFS_CONTROL, {4'h0, s[0], 3'h6});
      repeat (8) @(posedge aclk);
      rd(DCC_OFS_CONTROL, {s[0], !s[0], 2'b00, s[0], 3'h6});
    end
    // a write with lane 0 unstrobed must leave the control bits alone
    s_axi_wstrb <= 4'h0;
    wr(DCC_OFS_CONTROL, 8'h07);
    s_axi_wstrb <= 4'h1;
    rd(DCC_OFS_CONTROL, 8'h8E);
    check34({26'h0, port_f_out & DCC_PORT_MASK},
            {26'h0, ~r & DCC_PORT_MASK});
    port_f_in <= 8'($random(seed));
    analog_pin_select <= 8'($random(seed));
    repeat (5) @(posedge aclk);
    rd(DCC_OFS_PORT,
       port_f_in & ~analog_pin_select & DCC_PORT_MASK);
    give_verdict();
  end
endmodule

`default_nettype wire
